// ==== hdl/monitor_regs_pkg.sv ====
// Summary of operation
// - Remote two lower limit at 67h, reset 800h
// - Remote two upper limit, 12-bit read/write
// - Each alarm detector uses its own deadband
// - Deadband A: input0 bits 14-8, input1 bits 7-1
// - Deadband B: inputs 2 and 3, reset 0810h
// - Temperature deadbands at 14-10, 9-5, 4-0
// - Temperature fields 0-31 degrees, reset 2108h
// - Power bit 14 turns converter on
// - Power bit 13 turns reference buffer on
// - Bits 12-1 power DAC0 to DAC11
// - Differential channels compare in two's complement
package monitor_regs_pkg;

  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int NUM_REGS = 6;
  localparam int LIMIT_W = 12;
  localparam int DB_W = 8;

  typedef logic [REG_W-1:0] reg_word_t;
  typedef logic [IDX_W-1:0] reg_index_t;

  // Register indices; byte address is four times the index
  localparam reg_index_t IDX_R2_HIGH = 10'h066;
  localparam reg_index_t IDX_R2_LOW = 10'h067;
  localparam reg_index_t IDX_DB_A = 10'h068;
  localparam reg_index_t IDX_DB_B = 10'h069;
  localparam reg_index_t IDX_DB_TEMP = 10'h06A;
  localparam reg_index_t IDX_POWER = 10'h06B;

  // Storage slots
  localparam int SLOT_R2_HIGH = 0;
  localparam int SLOT_R2_LOW = 1;
  localparam int SLOT_DB_A = 2;
  localparam int SLOT_DB_B = 3;
  localparam int SLOT_DB_TEMP = 4;
  localparam int SLOT_POWER = 5;

  localparam reg_index_t REG_INDEX [NUM_REGS] = '{
    IDX_R2_HIGH, IDX_R2_LOW, IDX_DB_A, IDX_DB_B, IDX_DB_TEMP, IDX_POWER};
  // Writable bits; all others are reserved and read as zero
  localparam reg_word_t REG_MASK [NUM_REGS] = '{
    16'h0FFF, 16'h0FFF, 16'h7FFE, 16'h7FFE, 16'h7FFF, 16'h7FFE};
  localparam reg_word_t REG_RESET [NUM_REGS] = '{
    16'h07FF, 16'h0800, 16'h0810, 16'h0810, 16'h2108, 16'h0000};

  // Field positions
  localparam int LIMIT_LSB = 0;
  localparam int IN_DB_W = 7;
  localparam int IN_EVEN_DB_LSB = 8;
  localparam int IN_ODD_DB_LSB = 1;
  localparam int TEMP_DB_W = 5;
  localparam int REMOTE2_DB_LSB = 10;
  localparam int REMOTE1_DB_LSB = 5;
  localparam int LOCAL_DB_LSB = 0;
  localparam int TEMP_FRAC_BITS = 3;
  localparam int PWR_ADC_BIT = 14;
  localparam int PWR_REF_BIT = 13;
  localparam int PWR_DAC0_BIT = 12;
  localparam int NUM_DACS = 12;

  // Alarm detector slots
  localparam int DET_IN0 = 0;
  localparam int DET_IN1 = 1;
  localparam int DET_IN2 = 2;
  localparam int DET_IN3 = 3;
  localparam int DET_LOCAL = 4;
  localparam int DET_REMOTE1 = 5;
  localparam int DET_REMOTE2 = 6;
  localparam int NUM_DET = 7;
  localparam int NUM_EXT = 6;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : monitor_regs_pkg

// ==== hdl/deadband_alarm.sv ====
`timescale 1ns/1ps
`default_nettype none
// Window comparator with a deadband before the alarm may drop
module deadband_alarm
  import monitor_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample_valid,
  input wire logic [LIMIT_W-1:0] sample_data,
  input wire logic signed_mode,
  input wire logic [LIMIT_W-1:0] upper_limit_value,
  input wire logic [LIMIT_W-1:0] lower_limit_value,
  input wire logic [DB_W-1:0] deadband,
  output logic alarm_r
);

  logic signed [LIMIT_W+1:0] val_s;
  logic signed [LIMIT_W+1:0] up_s;
  logic signed [LIMIT_W+1:0] lo_s;
  logic signed [LIMIT_W+1:0] db_s;
  logic above;
  logic below;
  logic clear_ok;
  logic alarm_nxt;

  // Sign or zero extension per input format
  assign val_s = signed_mode ? {{2{sample_data[LIMIT_W-1]}}, sample_data}
                             : {2'b00, sample_data};
  assign up_s = signed_mode
    ? {{2{upper_limit_value[LIMIT_W-1]}}, upper_limit_value}
    : {2'b00, upper_limit_value};
  assign lo_s = signed_mode
    ? {{2{lower_limit_value[LIMIT_W-1]}}, lower_limit_value}
    : {2'b00, lower_limit_value};
  assign db_s = {{(LIMIT_W+2-DB_W){1'b0}}, deadband};

  // Outside the window; crossed limits leave this always true
  assign above = val_s > up_s;
  assign below = val_s < lo_s;
  assign clear_ok = (val_s <= up_s - db_s) && (val_s >= lo_s + db_s);
  assign alarm_nxt = (above || below) ? 1'b1
                   : (clear_ok ? 1'b0 : alarm_r);

  // Flag updates only on a new sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_r <= 1'b0;
    end else if (sample_valid) begin
      alarm_r <= alarm_nxt;
    end
  end

  property p_set_on_excursion;
    @(posedge aclk) disable iff (!aresetn)
      sample_valid && (above || below) |=> alarm_r;
  endproperty
  a_set_on_excursion: assert property (p_set_on_excursion)
    else $error("alarm not set on limit excursion");

  a_hold_in_band: assert property (
    @(posedge aclk) disable iff (!aresetn)
      alarm_r && sample_valid && !clear_ok |=> alarm_r)
    else $error("alarm dropped inside deadband");

  a_clear_past_band: assert property (
    @(posedge aclk) disable iff (!aresetn)
      sample_valid && !above && !below && clear_ok |=> !alarm_r)
    else $error("alarm not cleared past deadband");

  a_idle_stable: assert property (
    @(posedge aclk) disable iff (!aresetn)
      !sample_valid |=> $stable(alarm_r))
    else $error("alarm moved without a sample");

endmodule : deadband_alarm
`default_nettype wire

// ==== hdl/monitor_alarm_regs.sv ====
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Alarm limit, deadband and power register bank on AXI4-Lite
module monitor_alarm_regs
  import monitor_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // Write data channel
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W/8-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address channel
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // Read data channel
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Conversion results from the converter sequencer
  input wire logic sample_valid,
  input wire logic [2:0] sample_slot,
  input wire logic [LIMIT_W-1:0] sample_data,
  input wire logic [1:0] diff_pair_mode,
  // Limits held in neighbouring register banks
  input wire logic [NUM_EXT-1:0][LIMIT_W-1:0] upper_limit_value,
  input wire logic [NUM_EXT-1:0][LIMIT_W-1:0] lower_limit_value,
  // Alarm and power outputs
  output logic [NUM_DET-1:0] channel_alarm_flag,
  output logic converter_power_on,
  output logic refbuf_power_on,
  output logic [NUM_DACS-1:0] dac_output_power_on
);

  // Bus side state
  logic aw_full_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic w_full_r;
  logic [DATA_W-1:0] w_data_r;
  logic [DATA_W/8-1:0] w_strb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;

  // Register storage
  reg_word_t reg_r [NUM_REGS];
  reg_word_t reg_nxt [NUM_REGS];

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic aw_full_nxt;
  logic w_full_nxt;
  logic rvalid_nxt;
  reg_index_t wr_index;
  reg_index_t rd_index;
  logic [NUM_REGS-1:0] wr_hit;
  logic [NUM_REGS-1:0] rd_hit;
  logic wr_hit_any;
  logic rd_hit_any;
  reg_word_t rd_word;

  // Handshakes and write scheduling
  assign aw_take = awvalid && awready_r;
  assign w_take = wvalid && wready_r;
  assign ar_take = arvalid && arready_r;
  assign do_write = aw_full_r && w_full_r && !bvalid_r;
  assign aw_full_nxt = (aw_full_r && !do_write) || aw_take;
  assign w_full_nxt = (w_full_r && !do_write) || w_take;
  assign rvalid_nxt = (rvalid_r && !rready) || ar_take;

  // Address decode on word index
  assign wr_index = aw_addr_r[ADDR_W-1:2];
  assign rd_index = araddr[ADDR_W-1:2];
  assign wr_hit_any = |wr_hit;
  assign rd_hit_any = |rd_hit;

  // Byte-lane merge; reserved bits forced to zero
  function automatic reg_word_t merge_word(
    input reg_word_t old_word,
    input logic [DATA_W-1:0] data,
    input logic [DATA_W/8-1:0] strb,
    input reg_word_t mask
  );
    reg_word_t w;
    w = old_word;
    if (strb[0]) begin
      w[7:0] = data[7:0];
    end
    if (strb[1]) begin
      w[15:8] = data[15:8];
    end
    return w & mask;
  endfunction : merge_word

  // Per-register decode and next value
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      assign wr_hit[gi] = (wr_index == REG_INDEX[gi]);
      assign rd_hit[gi] = (rd_index == REG_INDEX[gi]);
      assign reg_nxt[gi] = merge_word(reg_r[gi], w_data_r, w_strb_r,
                                      REG_MASK[gi]);
    end
  endgenerate

  // Register storage with documented reset values
  always_ff @(posedge aclk) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      if (!aresetn) begin
        reg_r[i] <= REG_RESET[i];
      end else if (do_write && wr_hit[i]) begin
        reg_r[i] <= reg_nxt[i];
      end
    end
  end

  // Read multiplexer
  always_comb begin
    rd_word = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (rd_hit[i]) begin
        rd_word = reg_r[i];
      end
    end
  end

  // Write address and data holding stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= !aw_full_nxt;
      wready_r <= !w_full_nxt;
    end
  end

  // Captured write payload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else begin
      if (aw_take) begin
        aw_addr_r <= awaddr;
      end
      if (w_take) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit_any ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel; one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      arready_r <= !rvalid_nxt;
      if (ar_take) begin
        rdata_r <= {{(DATA_W-REG_W){1'b0}}, rd_word};
        rresp_r <= rd_hit_any ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // Power controls taken straight from the register bits
  assign converter_power_on = reg_r[SLOT_POWER][PWR_ADC_BIT];
  assign refbuf_power_on = reg_r[SLOT_POWER][PWR_REF_BIT];
  generate
    for (gi = 0; gi < NUM_DACS; gi++) begin : g_dac
      assign dac_output_power_on[gi] =
        reg_r[SLOT_POWER][PWR_DAC0_BIT-gi];
    end
  endgenerate

  // Per-detector limits, deadbands and number format
  logic [LIMIT_W-1:0] det_upper [NUM_DET];
  logic [LIMIT_W-1:0] det_lower [NUM_DET];
  logic [DB_W-1:0] det_db [NUM_DET];
  logic [NUM_DET-1:0] det_signed;

  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
      assign det_upper[gi] = upper_limit_value[gi];
      assign det_lower[gi] = lower_limit_value[gi];
    end
  endgenerate
  assign det_upper[DET_REMOTE2] = reg_r[SLOT_R2_HIGH][LIMIT_W-1:0];
  assign det_lower[DET_REMOTE2] = reg_r[SLOT_R2_LOW][LIMIT_W-1:0];

  // Input deadbands in converter codes
  assign det_db[DET_IN0] = {1'b0,
    reg_r[SLOT_DB_A][IN_EVEN_DB_LSB +: IN_DB_W]};
  assign det_db[DET_IN1] = {1'b0,
    reg_r[SLOT_DB_A][IN_ODD_DB_LSB +: IN_DB_W]};
  assign det_db[DET_IN2] = {1'b0,
    reg_r[SLOT_DB_B][IN_EVEN_DB_LSB +: IN_DB_W]};
  assign det_db[DET_IN3] = {1'b0,
    reg_r[SLOT_DB_B][IN_ODD_DB_LSB +: IN_DB_W]};
  // Whole degrees scaled to eighth-degree temperature codes
  assign det_db[DET_LOCAL] = {
    reg_r[SLOT_DB_TEMP][LOCAL_DB_LSB +: TEMP_DB_W],
    {TEMP_FRAC_BITS{1'b0}}};
  assign det_db[DET_REMOTE1] = {
    reg_r[SLOT_DB_TEMP][REMOTE1_DB_LSB +: TEMP_DB_W],
    {TEMP_FRAC_BITS{1'b0}}};
  assign det_db[DET_REMOTE2] = {
    reg_r[SLOT_DB_TEMP][REMOTE2_DB_LSB +: TEMP_DB_W],
    {TEMP_FRAC_BITS{1'b0}}};

  // Differential pairs compare signed; temperatures always signed
  assign det_signed = {3'b111, 1'b0, diff_pair_mode[1], 1'b0,
                       diff_pair_mode[0]};

  // One deadband detector per alarm source
  generate
    for (gi = 0; gi < NUM_DET; gi++) begin : g_det
      deadband_alarm u_det (
        .aclk(aclk),
        .aresetn(aresetn),
        .sample_valid(sample_valid && (sample_slot == 3'(gi))),
        .sample_data(sample_data),
        .signed_mode(det_signed[gi]),
        .upper_limit_value(det_upper[gi]),
        .lower_limit_value(det_lower[gi]),
        .deadband(det_db[gi]),
        .alarm_r(channel_alarm_flag[gi])
      );
    end
  endgenerate

  // Write completes one cycle after address and data are both held and no write response is still pending
  sequence s_write_pair;
    aw_full_r && w_full_r && !bvalid_r;
  endsequence

  sequence s_write_answer;
    bvalid_r ##0 (bresp_r == (wr_hit_any ? RESP_OKAY : RESP_SLVERR));
  endsequence

  a_write_response: assert property (
    @(posedge aclk) disable iff (!aresetn)
      s_write_pair |=> bvalid_r)
    else $error("write not answered in one cycle");

  a_read_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
      rvalid_r && !rready |=> rvalid_r && $stable(rdata_r))
    else $error("read data moved before rready");

  a_unmapped_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
      ar_take && !rd_hit_any |=> rresp_r == RESP_SLVERR && rdata_r == '0)
    else $error("unmapped read not refused");

  a_limit_reserved: assert property (
    @(posedge aclk) disable iff (!aresetn)
      reg_r[SLOT_R2_LOW][REG_W-1:LIMIT_W] == '0 &&
      reg_r[SLOT_R2_HIGH][REG_W-1:LIMIT_W] == '0)
    else $error("limit reserved bits set");

  a_deadband_reserved: assert property (
    @(posedge aclk) disable iff (!aresetn)
      reg_r[SLOT_DB_A][15] == 1'b0 && reg_r[SLOT_DB_A][0] == 1'b0 &&
      reg_r[SLOT_DB_B][15] == 1'b0 && reg_r[SLOT_DB_B][0] == 1'b0)
    else $error("deadband reserved bits set");

  a_temp_reset: assert property (
    @(posedge aclk)
      !aresetn |=> reg_r[SLOT_DB_TEMP] == 16'h2108)
    else $error("temperature deadband reset wrong");

  a_power_reset: assert property (
    @(posedge aclk)
      !aresetn |=> !converter_power_on && !refbuf_power_on &&
                   dac_output_power_on == '0)
    else $error("power controls not off after reset");

  a_dac_order: assert property (
    @(posedge aclk) disable iff (!aresetn)
      dac_output_power_on[0] == reg_r[SLOT_POWER][12] &&
      dac_output_power_on[11] == reg_r[SLOT_POWER][1])
    else $error("DAC power bit order wrong");

  a_power_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
      s_write_pair ##0 (wr_index == IDX_POWER && w_strb_r[1])
      |=> converter_power_on == $past(w_data_r[PWR_ADC_BIT]) &&
          refbuf_power_on == $past(w_data_r[PWR_REF_BIT]) ##0
          s_write_answer)
    else $error("power write not applied");

endmodule : monitor_alarm_regs
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
  import monitor_regs_pkg::*;
;
  localparam logic [11:0] RADDR [6] = '{12'h198, 12'h19C, 12'h1A0,
    12'h1A4, 12'h1A8, 12'h1AC};
  localparam logic [15:0] RRST [6] = '{16'h07FF, 16'h0800, 16'h0810,
    16'h0810, 16'h2108, 16'h0000};
  localparam logic [15:0] RMSK [6] = '{16'h0FFF, 16'h0FFF, 16'h7FFE,
    16'h7FFE, 16'h7FFF, 16'h7FFE};
  logic aclk, aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [DATA_W-1:0] wdata, rdata;
  logic [DATA_W/8-1:0] wstrb;
  logic [1:0] bresp, rresp, diff_pair_mode, resp;
  logic sample_valid;
  logic [2:0] sample_slot;
  logic [LIMIT_W-1:0] sample_data;
  logic [NUM_EXT-1:0][LIMIT_W-1:0] upper_limit_value, lower_limit_value;
  logic [NUM_DET-1:0] channel_alarm_flag;
  logic converter_power_on, refbuf_power_on;
  logic [NUM_DACS-1:0] dac_output_power_on;
  logic [31:0] rd;
  int miscompares, n_compared;

  monitor_alarm_regs dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .sample_valid(sample_valid),
    .sample_slot(sample_slot), .sample_data(sample_data),
    .diff_pair_mode(diff_pair_mode),
    .upper_limit_value(upper_limit_value),
    .lower_limit_value(lower_limit_value),
    .channel_alarm_flag(channel_alarm_flag),
    .converter_power_on(converter_power_on),
    .refbuf_power_on(refbuf_power_on),
    .dac_output_power_on(dac_output_power_on));

  // Free-running 10 MHz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Verdict and end of run
  task automatic conclude;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask : chk

  task automatic timed_out(input string nm);
    $display("unexpected %s: expected answer seen none", nm);
    miscompares++;
    conclude();
  endtask : timed_out

  // Write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 64) timed_out("write response");
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  // Read and compare data and response
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
      input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 64) timed_out("read data");
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    chk("rdata", rd, exp);
    chk("rresp", 32'(resp), 32'(er));
  endtask : rchk

  // One conversion result, then the alarm flag of its slot
  task automatic smp(input logic [2:0] sl, input logic [11:0] v,
      input logic e);
    @(posedge aclk);
    sample_valid <= 1'b1;
    sample_slot <= sl;
    sample_data <= v;
    @(posedge aclk);
    sample_valid <= 1'b0;
    #1;
    chk("alarm flag", 32'(channel_alarm_flag[sl]), 32'(e));
  endtask : smp

  task automatic pwr_chk(input logic c, input logic f,
      input logic [11:0] d);
    #1;
    chk("adc power", 32'(converter_power_on), 32'(c));
    chk("ref power", 32'(refbuf_power_on), 32'(f));
    chk("dac power", 32'(dac_output_power_on), 32'(d));
  endtask : pwr_chk

  // Main sequence
  initial begin
    miscompares = 0;
    n_compared = 0;
    aresetn = 1'b0;
    {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {sample_valid, sample_slot, sample_data, diff_pair_mode} = '0;
    upper_limit_value = '0;
    lower_limit_value = '0;
    upper_limit_value[5] = 12'h100;
    upper_limit_value[0] = 12'h800;
    lower_limit_value[0] = 12'h100;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    pwr_chk(1'b0, 1'b0, 12'h000);
    for (int i = 0; i < 6; i++) begin
      rchk(RADDR[i], 32'(RRST[i]), RESP_OKAY);
    end
    // All ones in, only defined fields come back
    for (int i = 0; i < 6; i++) begin
      axi_wr(RADDR[i], 32'hFFFFFFFF, 4'hF, resp);
      chk("bresp", 32'(resp), 32'(RESP_OKAY));
      rchk(RADDR[i], 32'(RMSK[i]), RESP_OKAY);
      axi_wr(RADDR[i], 32'(RRST[i]), 4'hF, resp);
    end
    // Unmapped places answer with an error and read zero
    axi_wr(12'h1B0, 32'h0000FFFF, 4'hF, resp);
    chk("bresp", 32'(resp), 32'(RESP_SLVERR));
    rchk(12'h1B0, 32'h0, RESP_SLVERR);
    rchk(12'h194, 32'h0, RESP_SLVERR);
    // Low lane only
    axi_wr(12'h1A0, 32'h0000FFFF, 4'h1, resp);
    rchk(12'h1A0, 32'h08FE, RESP_OKAY);
    axi_wr(12'h1A0, 32'h0810, 4'hF, resp);
    // Power bits and DAC order
    axi_wr(12'h1AC, 32'h5002, 4'hF, resp);
    pwr_chk(1'b1, 1'b0, 12'h801);
    axi_wr(12'h1AC, 32'h2800, 4'hF, resp);
    pwr_chk(1'b0, 1'b1, 12'h002);
    // Remote two window 0..100h with an 8 degree deadband
    axi_wr(12'h198, 32'h100, 4'hF, resp);
    axi_wr(12'h19C, 32'h000, 4'hF, resp);
    smp(3'd6, 12'h080, 1'b0);
    smp(3'd6, 12'h101, 1'b1);
    smp(3'd6, 12'h0F0, 1'b1);
    smp(3'd6, 12'h0C0, 1'b0);
    smp(3'd6, 12'hFFF, 1'b1);
    smp(3'd6, 12'h03F, 1'b1);
    smp(3'd6, 12'h040, 1'b0);
    // Remote two deadband zero, remote one keeps its own
    axi_wr(12'h1A8, 32'h0108, 4'hF, resp);
    smp(3'd6, 12'h101, 1'b1);
    smp(3'd6, 12'h100, 1'b0);
    smp(3'd5, 12'h101, 1'b1);
    smp(3'd5, 12'h0F0, 1'b1);
    // Input zero, unsigned, deadband 8 then 16
    smp(3'd0, 12'hF00, 1'b1);
    smp(3'd0, 12'h7F9, 1'b1);
    smp(3'd0, 12'h7F8, 1'b0);
    axi_wr(12'h1A0, 32'h1010, 4'hF, resp);
    smp(3'd0, 12'h801, 1'b1);
    smp(3'd0, 12'h7F8, 1'b1);
    smp(3'd0, 12'h7F0, 1'b0);
    // Inputs zero and two as differential pairs
    @(posedge aclk);
    upper_limit_value[0] <= 12'h100;
    lower_limit_value[0] <= 12'hF00;
    upper_limit_value[2] <= 12'h100;
    lower_limit_value[2] <= 12'hF00;
    diff_pair_mode <= 2'b01;
    smp(3'd0, 12'h000, 1'b0);
    @(posedge aclk);
    diff_pair_mode <= 2'b00;
    smp(3'd0, 12'h000, 1'b1);
    smp(3'd2, 12'h000, 1'b1);
    @(posedge aclk);
    diff_pair_mode <= 2'b11;
    smp(3'd0, 12'h000, 1'b0);
    smp(3'd2, 12'h000, 1'b0);
    conclude();
  end
endmodule : tb
`default_nettype wire
